// file: rtl/smme_map.svh
// Purpose: Offsets, field positions, reset values and header layout for the mgmt entry block
// Assumes: Included by its bare name
// Notes: Definitions only
`ifndef SMME_MAP_SVH
`define SMME_MAP_SVH
`define SMME_IDX_CFG_CTRL_ONE 8'hc1
`define SMME_IDX_CFG_CTRL_THREE 8'hc3
`define SMME_IDX_REGION_B0 8'hcd
`define SMME_IDX_REGION_B1 8'hce
`define SMME_IDX_REGION_B2 8'hcf
`define SMME_IDX_HDR_B0 8'hb0
`define SMME_IDX_HDR_B1 8'hb1
`define SMME_IDX_HDR_B2 8'hb2
`define SMME_IDX_HDR_B3 8'hb3
`define SMME_IDX_STATUS 8'hb4
`define SMME_BIT_ACCESS_EN 2
`define SMME_BIT_PIN_EN 1
`define SMME_BIT_MAP_EN 4
`define SMME_CFG_RST 8'h00
`define SMME_REGION_RST 24'h000000
`define SMME_HDR_RST 32'h00000000
`define SMME_HDR_ALIGN_MASK 32'hfffffffc
`define SMME_SIZE_BYTE 8'h01
`define SMME_SIZE_WORD 8'h03
`define SMME_SIZE_DWORD 8'h0f
`define SMME_OFF_DEBUG 8'h04
`define SMME_OFF_FLAGS 8'h08
`define SMME_OFF_CTRL0 8'h0c
`define SMME_OFF_CUR_IP 8'h10
`define SMME_OFF_NEXT_INSTR_PTR 8'h14
`define SMME_OFF_STATUS 8'h24
`define SMME_OFF_IO_SIZE_ADDR 8'h28
`define SMME_OFF_DATA 8'h2c
`define SMME_OFF_MEM_ADDR 8'h40
`define SMME_HDR_WORDS 9
`define SMME_ST_NEST 8
`define SMME_ST_VGA 7
`define SMME_ST_EXT 6
`define SMME_ST_MEM 5
`define SMME_ST_HALT 4
`define SMME_ST_SOFT 3
`define SMME_ST_REP 2
`define SMME_ST_WRITE 1
`define SMME_PIN_MIN_LOW_NS 100
`define SMME_CLK_PERIOD_NS 50
`define SMME_PIN_MIN_LOW_CYC ((`SMME_PIN_MIN_LOW_NS + `SMME_CLK_PERIOD_NS - 1) / `SMME_CLK_PERIOD_NS)
`endif

// file: rtl/smme_pkg.sv
// Purpose: Types for the mgmt entry block
// Assumes: Constants come from smme_map.svh
// Notes: Packed structs carry grouped signals
package smme_pkg;
   typedef enum logic [1:0] {
      SMME_SRC_PIN,
      SMME_SRC_INSTR,
      SMME_SRC_IO,
      SMME_SRC_MEM
   } smme_src_e;
   typedef struct packed {
      logic [31:0] debug_control_reg;
      logic [31:0] flags_reg;
      logic [31:0] control_reg_zero;
      logic [31:0] current_instr_ptr;
      logic [31:0] next_instr_ptr;
      logic halted;
   } smme_cpu_s;
   typedef struct packed {
      logic io_trap;
      logic mem_trap;
      logic vga_region;
      logic is_write;
      logic rep_string;
      logic [1:0] size_code;
      logic [15:0] io_addr;
      logic [31:0] mem_addr;
      logic [31:0] data;
   } smme_trap_s;
   typedef struct packed {
      logic we;
      logic [7:0] offset;
      logic [31:0] data;
   } smme_hdr_wr_s;
endpackage

// file: rtl/smme_entry.sv
// Purpose: Entry, header save and resume logic for system management mode
// Assumes: Single 20 MHz clock, synchronous active-high reset
// Notes: Header words are written downward from the header address
//
// Overview of operation
// - Entry instruction enters management mode without pin activity.
// - Triggers honoured only once region and enable bits are programmed.
// - Management request outranks every other pending interrupt, NMI included.
// - Save header at top of region, then enter real mode at base.
// - Pin is edge sensitive; a falling edge raises a request.
// - Resume re-raises request if pin is low, unless it stayed low since last request.
// - Trapped I/O and selected memory accesses raise internal requests.
// - Header address low two bits are ignored.
// - Writing region register recomputes and overwrites the header address.
// - Region and header registers accessible only with map enable set.
// - Trapped memory address saved at header offset minus 40h.
// - Memory data shares the I/O data slot.
// - I/O address always valid, I/O data on writes; memory likewise.
// - Current pointer saved; meaningful for internal I/O traps only.
// - Next pointer, debug control, flags and control zero are saved.
// - Repeated string I/O trap saves equal pointers; write and repeat flags valid.
// - Port and size saved only for I/O bus cycle requests; data also for memory writes.
// - Resume does not reload trap information.
// - Asynchronous external requests arrive through the pin.
// - Access-type flag is 0 for I/O, 1 for memory.
// - Size encodes byte 01h, word 03h, doubleword 0Fh.
// - External flag is 1 for pin requests, 0 for internal.
// - Software flag is 1 for instruction-started sessions.
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`include "smme_map.svh"
module smme_entry (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_mgmt_interrupt_n,
   input wire logic i_mgmt_entry_instruction,
   input wire logic i_resume_from_mgmt,
   input wire logic i_nmi_pending,
   input wire smme_pkg::smme_trap_s i_trap,
   input wire smme_pkg::smme_cpu_s i_cpu,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   output smme_pkg::smme_hdr_wr_s o_hdr_wr,
   output logic [31:0] o_hdr_base,
   output logic [31:0] o_fetch_addr,
   output logic o_fetch_go,
   output logic o_real_mode,
   output logic o_in_mgmt,
   output logic o_nmi_take
);
   import smme_pkg::*;

   // Entry sequencer states
   typedef enum logic [1:0] {
      SMME_IDLE,
      SMME_SAVE,
      SMME_RUN
   } smme_state_e;

   // Pin sampling and edge history
   logic [1:0] pin_sync_r;
   logic pin_q_r;
   // Configuration state
   logic [7:0] cfg_one_r;
   logic [7:0] cfg_three_r;
   logic [23:0] region_r;
   logic [31:0] hdr_addr_r;
   // Sequencer state
   smme_state_e state_r;
   logic [3:0] word_r;
   logic pin_req_r;
   logic held_low_r;
   logic nested_r;
   smme_src_e src_r;
   // Latched at entry, so inputs may drop once the request is taken
   smme_cpu_s cpu_r;
   smme_trap_s trap_r;
   // Decodes
   logic enabled;
   logic pin_fall;
   logic int_req;
   logic map_en;

   // Region base: top 20 bits in [23:4] of the region register, byte aligned to 4 KB
   function automatic logic [31:0] region_base(input logic [23:0] r);
      return {r[23:4], 12'h000};
   endfunction

   // Region size field: 4 KB units times 2^code
   function automatic logic [31:0] region_top(input logic [23:0] r);
      logic [31:0] sz;
      sz = 32'h00001000 << r[3:0];
      return region_base(r) + sz;
   endfunction

   // Trap size code to header encoding; unknown codes read as doubleword
   function automatic logic [7:0] size_enc(input logic [1:0] c);
      case (c)
         2'h0: return `SMME_SIZE_BYTE;
         2'h1: return `SMME_SIZE_WORD;
         default: return `SMME_SIZE_DWORD;
      endcase
   endfunction

   // Requests count only with a region and at least one enable bit
   assign map_en = cfg_three_r[`SMME_BIT_MAP_EN];
   assign enabled = (region_r[3:0] != 4'h0 || region_r[23:4] != 20'h0) &&
      (cfg_one_r[`SMME_BIT_ACCESS_EN] || cfg_one_r[`SMME_BIT_PIN_EN]);
   // High-to-low step seen on the synchronised pin
   assign pin_fall = pin_q_r & ~pin_sync_r[1];
   assign int_req = i_trap.io_trap | i_trap.mem_trap;

   // Two-flop pin synchroniser, then edge history flop
   // Reset to the idle-high level so no false edge follows reset
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pin_sync_r <= 2'h3;
         pin_q_r <= 1'b1;
      end else if (i_ce) begin
         pin_sync_r <= {pin_sync_r[0], i_mgmt_interrupt_n};
         pin_q_r <= pin_sync_r[1];
      end
   end

   // Pending pin request; a falling edge wins over consumption
   // Held-low flag stops a pin still low at resume from re-raising
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pin_req_r <= 1'b0;
         held_low_r <= 1'b0;
      end else if (i_ce) begin
         if (pin_fall && enabled && cfg_one_r[`SMME_BIT_PIN_EN]) begin
            pin_req_r <= 1'b1;
         end else if (state_r == SMME_RUN && i_resume_from_mgmt && !held_low_r &&
               pin_sync_r[1] == 1'b0) begin
            pin_req_r <= 1'b1;
         end else if (state_r == SMME_IDLE && pin_req_r) begin
            pin_req_r <= 1'b0;
         end
         if (state_r == SMME_IDLE && pin_req_r) begin
            held_low_r <= ~pin_sync_r[1];
         end else if (pin_sync_r[1]) begin
            held_low_r <= 1'b0;
         end
      end
   end

   // Configuration registers
   // A region write rewrites the header address, so program region first
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cfg_one_r <= `SMME_CFG_RST;
         cfg_three_r <= `SMME_CFG_RST;
         region_r <= `SMME_REGION_RST;
         hdr_addr_r <= `SMME_HDR_RST;
      end else if (i_ce && i_wr) begin
         case (i_addr)
            `SMME_IDX_CFG_CTRL_ONE: cfg_one_r <= i_wdata;
            `SMME_IDX_CFG_CTRL_THREE: cfg_three_r <= i_wdata;
            `SMME_IDX_REGION_B0, `SMME_IDX_REGION_B1, `SMME_IDX_REGION_B2: begin
               if (map_en) begin
                  case (i_addr)
                     `SMME_IDX_REGION_B0: begin
                        region_r[7:0] <= i_wdata;
                        hdr_addr_r <= region_top({region_r[23:8], i_wdata});
                     end
                     `SMME_IDX_REGION_B1: begin
                        region_r[15:8] <= i_wdata;
                        hdr_addr_r <= region_top({region_r[23:16], i_wdata,
                           region_r[7:0]});
                     end
                     default: begin
                        region_r[23:16] <= i_wdata;
                        hdr_addr_r <= region_top({i_wdata, region_r[15:0]});
                     end
                  endcase
               end
            end
            `SMME_IDX_HDR_B0: if (map_en) hdr_addr_r[7:0] <= i_wdata;
            `SMME_IDX_HDR_B1: if (map_en) hdr_addr_r[15:8] <= i_wdata;
            `SMME_IDX_HDR_B2: if (map_en) hdr_addr_r[23:16] <= i_wdata;
            `SMME_IDX_HDR_B3: if (map_en) hdr_addr_r[31:24] <= i_wdata;
            default: ;
         endcase
      end
   end

   // Register read port, data one cycle after the strobe
   // Mapped indices read as zero while map enable is clear
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
      end else if (i_ce) begin
         if (i_rd) begin
            case (i_addr)
               `SMME_IDX_CFG_CTRL_ONE: o_rdata <= cfg_one_r;
               `SMME_IDX_CFG_CTRL_THREE: o_rdata <= cfg_three_r;
               `SMME_IDX_REGION_B0: o_rdata <= map_en ? region_r[7:0] : 8'h00;
               `SMME_IDX_REGION_B1: o_rdata <= map_en ? region_r[15:8] : 8'h00;
               `SMME_IDX_REGION_B2: o_rdata <= map_en ? region_r[23:16] : 8'h00;
               `SMME_IDX_HDR_B0: o_rdata <= map_en ? hdr_addr_r[7:0] : 8'h00;
               `SMME_IDX_HDR_B1: o_rdata <= map_en ? hdr_addr_r[15:8] : 8'h00;
               `SMME_IDX_HDR_B2: o_rdata <= map_en ? hdr_addr_r[23:16] : 8'h00;
               `SMME_IDX_HDR_B3: o_rdata <= map_en ? hdr_addr_r[31:24] : 8'h00;
               `SMME_IDX_STATUS: o_rdata <= {5'h00, held_low_r, pin_req_r, o_in_mgmt};
               default: o_rdata <= 8'h00;
            endcase
         end else begin
            o_rdata <= 8'h00;
         end
      end
   end

   // Entry, header save and resume sequencing
   // All outputs low in reset; fetch start is a one-cycle pulse
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_r <= SMME_IDLE;
         word_r <= 4'h0;
         nested_r <= 1'b0;
         src_r <= SMME_SRC_PIN;
         cpu_r <= '0;
         trap_r <= '0;
         o_in_mgmt <= 1'b0;
         o_real_mode <= 1'b0;
         o_fetch_go <= 1'b0;
         o_fetch_addr <= 32'h00000000;
         o_hdr_base <= 32'h00000000;
         o_nmi_take <= 1'b0;
      end else if (i_ce) begin
         o_fetch_go <= 1'b0;
         o_nmi_take <= 1'b0;
         case (state_r)
            SMME_IDLE: begin
               if (enabled && (pin_req_r || i_mgmt_entry_instruction || int_req)) begin
                  state_r <= SMME_SAVE;
                  word_r <= 4'h0;
                  src_r <= pin_req_r ? SMME_SRC_PIN :
                     i_mgmt_entry_instruction ? SMME_SRC_INSTR :
                     i_trap.io_trap ? SMME_SRC_IO : SMME_SRC_MEM;
                  cpu_r <= i_cpu;
                  trap_r <= i_trap;
                  o_hdr_base <= hdr_addr_r & `SMME_HDR_ALIGN_MASK;
               end else begin
                  // NMI passes only when no management request is taken
                  o_nmi_take <= i_nmi_pending;
               end
            end
            SMME_SAVE: begin
               if (word_r == 4'(`SMME_HDR_WORDS - 1)) begin
                  state_r <= SMME_RUN;
                  o_in_mgmt <= 1'b1;
                  o_real_mode <= 1'b1;
                  o_fetch_go <= 1'b1;
                  o_fetch_addr <= region_base(region_r);
                  // Nested flag is kept until the status word holding it is written
                  nested_r <= 1'b0;
               end
               word_r <= word_r + 4'h1;
            end
            SMME_RUN: begin
               // A pin request during the session stays pending; a pin or trap request marks the next entry nested
               if (pin_req_r || int_req) begin
                  nested_r <= 1'b1;
               end
               if (i_resume_from_mgmt) begin
                  state_r <= SMME_IDLE;
                  o_in_mgmt <= 1'b0;
                  o_real_mode <= 1'b0;
               end
            end
            default: state_r <= SMME_IDLE;
         endcase
      end
   end

   // Header word writer, one word a cycle during save
   // Offsets are bytes below the header base
   // I/O port and size, data, memory address, repeat and write flags are written as zero where the trap kind leaves them invalid
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_hdr_wr <= '0;
      end else if (i_ce) begin
         o_hdr_wr.we <= (state_r == SMME_SAVE);
         case (word_r)
            4'h0: begin
               o_hdr_wr.offset <= `SMME_OFF_DEBUG;
               o_hdr_wr.data <= cpu_r.debug_control_reg;
            end
            4'h1: begin
               o_hdr_wr.offset <= `SMME_OFF_FLAGS;
               o_hdr_wr.data <= cpu_r.flags_reg;
            end
            4'h2: begin
               o_hdr_wr.offset <= `SMME_OFF_CTRL0;
               o_hdr_wr.data <= cpu_r.control_reg_zero;
            end
            4'h3: begin
               o_hdr_wr.offset <= `SMME_OFF_CUR_IP;
               o_hdr_wr.data <= (src_r == SMME_SRC_IO && trap_r.rep_string) ?
                  cpu_r.next_instr_ptr : cpu_r.current_instr_ptr;
            end
            4'h4: begin
               o_hdr_wr.offset <= `SMME_OFF_NEXT_INSTR_PTR;
               o_hdr_wr.data <= cpu_r.next_instr_ptr;
            end
            4'h5: begin
               o_hdr_wr.offset <= `SMME_OFF_STATUS;
               o_hdr_wr.data <= '0;
               o_hdr_wr.data[`SMME_ST_NEST] <= nested_r;
               o_hdr_wr.data[`SMME_ST_VGA] <= trap_r.vga_region;
               o_hdr_wr.data[`SMME_ST_EXT] <= (src_r == SMME_SRC_PIN);
               o_hdr_wr.data[`SMME_ST_MEM] <= (src_r == SMME_SRC_MEM);
               o_hdr_wr.data[`SMME_ST_HALT] <= cpu_r.halted;
               o_hdr_wr.data[`SMME_ST_SOFT] <= (src_r == SMME_SRC_INSTR);
               o_hdr_wr.data[`SMME_ST_REP] <= trap_r.io_trap & trap_r.rep_string;
               o_hdr_wr.data[`SMME_ST_WRITE] <= trap_r.io_trap & trap_r.is_write;
            end
            4'h6: begin
               o_hdr_wr.offset <= `SMME_OFF_IO_SIZE_ADDR;
               o_hdr_wr.data <= trap_r.io_trap ?
                  {8'h00, size_enc(trap_r.size_code), trap_r.io_addr} : '0;
            end
            4'h7: begin
               o_hdr_wr.offset <= `SMME_OFF_DATA;
               o_hdr_wr.data <= ((trap_r.io_trap || trap_r.mem_trap) && trap_r.is_write) ?
                  trap_r.data : '0;
            end
            default: begin
               o_hdr_wr.offset <= `SMME_OFF_MEM_ADDR;
               o_hdr_wr.data <= trap_r.mem_trap ? trap_r.mem_addr : '0;
            end
         endcase
      end
   end
endmodule // smme_entry

// file: testbench/smme_chipset_model.sv
// Purpose: Chipset side model that drives the mgmt interrupt pin
// Assumes: Pin idles high through a pull-up
// Notes: Pin edges land 7 ns after the clock, unrelated to sampling
`timescale 1ns/100ps
module smme_chipset_model (
   input wire logic i_clk,
   input wire logic i_fire,
   input wire logic [7:0] i_low_cyc,
   output logic o_mgmt_interrupt_n
);
   logic [7:0] cnt_r = 8'h00;
   // One separate low pulse per event, length set by the caller
   always @(posedge i_clk) begin
      if (i_fire) begin
         cnt_r <= i_low_cyc;
      end else if (cnt_r != 8'h00) begin
         cnt_r <= cnt_r - 8'h01;
      end
   end
   // Pin moves off the clock edge, as an asynchronous source would
   assign #7 o_mgmt_interrupt_n = (cnt_r == 8'h00);
endmodule // smme_chipset_model

// file: testbench/smme_entry_properties.sv
// Purpose: Port-level checks of the mgmt entry block
// Assumes: Single clock, synchronous active-high reset
// Notes: Attached by bind
`timescale 1ns/100ps
module smme_entry_properties (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_mgmt_entry_instruction,
   input wire logic i_resume_from_mgmt,
   input wire logic i_nmi_pending,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire smme_pkg::smme_hdr_wr_s o_hdr_wr,
   input wire logic [31:0] o_hdr_base,
   input wire logic o_fetch_go,
   input wire logic o_real_mode,
   input wire logic o_in_mgmt,
   input wire logic o_nmi_take
);
   import smme_pkg::*;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   property p_rdata_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
   property p_hdr_align; o_hdr_base[1:0] == 2'b00; endproperty
   a_hdr_align: assert property (p_hdr_align) else $error("header base not aligned");
   property p_save_len;
      $rose(o_hdr_wr.we) |-> o_hdr_wr.we [*8] ##1 o_hdr_wr.we ##1 !o_hdr_wr.we;
   endproperty
   a_save_len: assert property (p_save_len) else $error("header save not nine words");
   property p_save_first; $rose(o_hdr_wr.we) |-> o_hdr_wr.offset == 8'h04; endproperty
   a_save_first: assert property (p_save_first) else $error("first header word misplaced");
   property p_save_last; $fell(o_hdr_wr.we) |-> $past(o_hdr_wr.offset) == 8'h40; endproperty
   a_save_last: assert property (p_save_last) else $error("last header word misplaced");
   property p_nmi_yield;
      i_mgmt_entry_instruction && i_nmi_pending |=> !o_nmi_take [*3];
   endproperty
   a_nmi_yield: assert property (p_nmi_yield) else $error("nmi taken over mgmt request");
   property p_resume_exit; o_in_mgmt && i_resume_from_mgmt |=> !o_in_mgmt; endproperty
   a_resume_exit: assert property (p_resume_exit) else $error("resume did not leave");
   property p_go_pulse; o_fetch_go |=> !o_fetch_go; endproperty
   a_go_pulse: assert property (p_go_pulse) else $error("fetch start not a pulse");
   property p_go_mode; o_fetch_go |-> ##[0:1] (o_in_mgmt && o_real_mode); endproperty
   a_go_mode: assert property (p_go_mode) else $error("fetch without real mode");
endmodule // smme_entry_properties
bind smme_entry smme_entry_properties u_smme_entry_properties (.i_clk(i_clk), .i_rst(i_rst),
   .i_mgmt_entry_instruction(i_mgmt_entry_instruction), .i_resume_from_mgmt(i_resume_from_mgmt),
   .i_nmi_pending(i_nmi_pending), .i_rd(i_rd), .o_rdata(o_rdata), .o_hdr_wr(o_hdr_wr),
   .o_hdr_base(o_hdr_base), .o_fetch_go(o_fetch_go), .o_real_mode(o_real_mode),
   .o_in_mgmt(o_in_mgmt), .o_nmi_take(o_nmi_take));

// file: testbench/testbench.sv
// Purpose: Register and entry sequences for the mgmt entry block
// Assumes: Chipset model drives the pin
// Notes: Header words are collected by offset
`timescale 1ns/100ps
`include "smme_map.svh"
module testbench;
   import smme_pkg::*;
   logic i_clk, i_rst, i_ce, pin_n, ins, resume_from_mgmt, nmi, wr, rd, fire, real_mode, in_mgmt, nmi_take, go;
   logic [7:0] addr, wdata, rdata, low_cyc;
   logic [31:0] hdr_base, fetch_addr;
   logic [31:0] hdr [0:255];
   smme_trap_s trap;
   smme_cpu_s cpu;
   smme_hdr_wr_s hdr_wr;
   int n_mismatch, compares, cyc;
   smme_entry u_smme_entry (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
      .i_mgmt_interrupt_n(pin_n), .i_mgmt_entry_instruction(ins), .i_resume_from_mgmt(resume_from_mgmt),
      .i_nmi_pending(nmi), .i_trap(trap), .i_cpu(cpu), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_hdr_wr(hdr_wr), .o_hdr_base(hdr_base),
      .o_fetch_addr(fetch_addr), .o_fetch_go(go), .o_real_mode(real_mode),
      .o_in_mgmt(in_mgmt), .o_nmi_take(nmi_take));
   smme_chipset_model u_smme_chipset_model (.i_clk(i_clk), .i_fire(fire), .i_low_cyc(low_cyc),
      .o_mgmt_interrupt_n(pin_n));
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      if (hdr_wr.we) hdr[hdr_wr.offset] <= hdr_wr.data;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         conclude();
      end
   end
   task automatic conclude();
      $display("Mismatches %0d, comparisons %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge i_clk);
      wr <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge i_clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic enter(input logic [31:0] st, input logic [31:0] msk);
      int n;
      n = 0;
      while (go !== 1'b1 && n < 100) begin
         @(posedge i_clk);
         #1 n++;
      end
      chk(n < 100, 1);
      repeat (2) @(posedge i_clk);
      #1 chk(fetch_addr, 32'h01234000);
      chk(hdr_base, 32'h01238000);
      chk(hdr[8'h04], cpu.debug_control_reg);
      chk(hdr[8'h08], cpu.flags_reg);
      chk(hdr[8'h0c], cpu.control_reg_zero);
      chk(hdr[8'h10], cpu.current_instr_ptr);
      chk(hdr[8'h14], cpu.next_instr_ptr);
      chk(hdr[8'h24] & msk, st);
   endtask
   task automatic leave(input logic [7:0] w);
      @(posedge i_clk);
      resume_from_mgmt <= 1'b1;
      @(posedge i_clk);
      resume_from_mgmt <= 1'b0;
      repeat (w) @(posedge i_clk);
      #1 chk(in_mgmt, 1'b0);
   endtask
   task automatic pulse_pin(input logic [7:0] len);
      @(posedge i_clk);
      low_cyc <= len;
      fire <= 1'b1;
      @(posedge i_clk);
      fire <= 1'b0;
   endtask
   initial begin
      i_rst = 1'b1; i_ce = 1'b1; ins = 1'b0; resume_from_mgmt = 1'b0; nmi = 1'b0; wr = 1'b0; rd = 1'b0;
      addr = 8'h00; wdata = 8'h00; fire = 1'b0; low_cyc = 8'h03; trap = '0;
      n_mismatch = 0; compares = 0; cyc = 0;
      cpu = '{32'h00000400, 32'h00000002, 32'h60000010, 32'h00001000, 32'h00001004, 1'b0};
      repeat (10) @(posedge i_clk);
      i_rst <= 1'b0;
      rdc(`SMME_IDX_CFG_CTRL_ONE, `SMME_CFG_RST);
      rdc(`SMME_IDX_REGION_B0, 8'h00);
      @(posedge i_clk) ins <= 1'b1;
      @(posedge i_clk) ins <= 1'b0;
      repeat (20) @(posedge i_clk);
      #1 chk(in_mgmt, 1'b0);
      wrr(`SMME_IDX_CFG_CTRL_THREE, 8'h10);
      wrr(`SMME_IDX_HDR_B3, 8'hff);
      wrr(`SMME_IDX_REGION_B0, 8'h42);
      wrr(`SMME_IDX_REGION_B1, 8'h23);
      wrr(`SMME_IDX_REGION_B2, 8'h01);
      rdc(`SMME_IDX_HDR_B3, 8'h01);
      rdc(`SMME_IDX_HDR_B2, 8'h23);
      rdc(`SMME_IDX_HDR_B1, 8'h80);
      wrr(`SMME_IDX_HDR_B0, 8'h03);
      rdc(8'h50, 8'h00);
      wrr(`SMME_IDX_CFG_CTRL_THREE, 8'h00);
      rdc(`SMME_IDX_HDR_B2, 8'h00);
      wrr(`SMME_IDX_HDR_B3, 8'h55);
      wrr(`SMME_IDX_CFG_CTRL_ONE, 8'h06);
      pulse_pin(8'h03);
      enter(32'h00000040, 32'hffffffff);
      pulse_pin(8'h03);
      repeat (5) @(posedge i_clk);
      @(posedge i_clk) resume_from_mgmt <= 1'b1;
      @(posedge i_clk) resume_from_mgmt <= 1'b0;
      enter(32'h00000140, 32'hffffffff);
      leave(8'h0a);
      pulse_pin(8'h40);
      enter(32'h00000040, 32'hffffffff);
      leave(8'h0a);
      repeat (60) @(posedge i_clk);
      @(posedge i_clk) begin ins <= 1'b1; nmi <= 1'b1; end
      @(posedge i_clk) ins <= 1'b0;
      enter(32'h00000008, 32'hffffffff);
      nmi <= 1'b0;
      leave(8'h05);
      for (int k = 0; k < 3; k++) begin
         @(posedge i_clk);
         cpu.current_instr_ptr <= 32'h00002000;
         cpu.next_instr_ptr <= 32'h00002000;
         trap <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 2'(k), 16'h03f8, 32'h0, 32'hdeadbeef};
         @(posedge i_clk) trap <= '0;
         enter(32'h00000006, 32'hffffffff);
         chk(hdr[8'h28], {8'h00, k == 0 ? 8'h01 : k == 1 ? 8'h03 : 8'h0f, 16'h03f8});
         chk(hdr[8'h2c], 32'hdeadbeef);
         leave(8'h05);
      end
      @(posedge i_clk);
      trap <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 2'd0, 16'h0, 32'h000a0010, 32'h5a5a1234};
      @(posedge i_clk) trap <= '0;
      enter(32'h000000a0, 32'hffffffff);
      chk(hdr[8'h40], 32'h000a0010);
      chk(hdr[8'h2c], 32'h5a5a1234);
      chk(hdr[8'h28], 32'h00000000);
      leave(8'h05);
      @(posedge i_clk) nmi <= 1'b1;
      @(posedge i_clk) nmi <= 1'b0;
      #1 chk(nmi_take, 1'b1);
      conclude();
   end
endmodule // testbench
